// ==== rtl/smr_edge.sv ====
`timescale 1ns/10ps
module smr_edge
(
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_ce,
	input  wire logic       i_level,
	input  wire logic [1:0] i_edge_sel,
	output logic            o_event
);
	logic prev_q;
	logic rise;
	logic fall;

	assign rise = i_level & ~prev_q;
	assign fall = ~i_level & prev_q;

	// ***************************************************************
	// Edge qualified by select code
	// ***************************************************************
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			prev_q  <= 1'b0;
			o_event <= 1'b0;
		end
		else if (i_ce)
		begin
			prev_q <= i_level;
			if (i_edge_sel == smr_pkg::EDGE_RISING)
				o_event <= rise;
			else if (i_edge_sel == smr_pkg::EDGE_FALLING)
				o_event <= fall;
			else if (i_edge_sel == smr_pkg::EDGE_BOTH)
				o_event <= rise | fall;
			else
				o_event <= 1'b0;
		end
	end
endmodule

// ==== rtl/smr_pkg.sv ====
package smr_pkg;
	// ***************************************************************
	// Register map (word addresses on the plain port)
	// ***************************************************************
	localparam logic [3:0] ADDR_LVD_CTL      = 4'h0;
	localparam logic [3:0] ADDR_INTR         = 4'h1;
	localparam logic [3:0] ADDR_INTR_SET     = 4'h2;
	localparam logic [3:0] ADDR_INTR_MASK    = 4'h3;
	localparam logic [3:0] ADDR_INTR_MASKED  = 4'h4;
	localparam logic [3:0] ADDR_INTR_CFG     = 4'h5;
	localparam logic [3:0] ADDR_RESET_STATUS = 4'h6;

	// ***************************************************************
	// Field layout
	// ***************************************************************
	localparam int TRIP_LSB   = 0;
	localparam int TRIP_W     = 4;
	localparam int SRC_LSB    = 4;
	localparam int SRC_W      = 3;
	localparam int EN_BIT     = 7;
	localparam int LVD_BIT    = 1;
	localparam int EDGE_LSB   = 0;
	localparam int EDGE_W     = 2;
	localparam int CTL_W      = 8;
	localparam int INTR_W     = 2;

	localparam logic [7:0]  LVD_CTL_RESET = 8'h00;
	localparam logic [1:0]  INTR_RESET    = 2'h0;
	localparam logic [31:0] READ_ZERO     = 32'h0000_0000;

	// ***************************************************************
	// Edge select codes
	// ***************************************************************
	localparam logic [1:0] EDGE_NONE    = 2'h0;
	localparam logic [1:0] EDGE_RISING  = 2'h1;
	localparam logic [1:0] EDGE_FALLING = 2'h2;
	localparam logic [1:0] EDGE_BOTH    = 2'h3;

	// ***************************************************************
	// Source select codes
	// ***************************************************************
	localparam logic [2:0] SRC_DIGITAL = 3'h0;
	localparam logic [2:0] SRC_BUS_A   = 3'h1;
	localparam logic [2:0] SRC_BUS_B   = 3'h2;
	localparam logic [2:0] SRC_IO      = 3'h3;

	// ***************************************************************
	// Power modes and reset sequencer
	// ***************************************************************
	typedef enum logic [2:0]
	{
		PM_ACTIVE     = 3'h0,
		PM_LP_ACTIVE  = 3'h1,
		PM_SLEEP      = 3'h2,
		PM_LP_SLEEP   = 3'h3,
		PM_DEEP_SLEEP = 3'h4,
		PM_HIBERNATE  = 3'h5
	} smr_mode_type;

	typedef enum logic [2:0]
	{
		ST_POWER_UP = 3'b001,
		ST_HOLD     = 3'b010,
		ST_RUN      = 3'b100
	} smr_state_type;

	localparam int RELEASE_NS = 100;
	localparam int CLK_MHZ    = 250;
	localparam int RELEASE_CYC = (RELEASE_NS * CLK_MHZ + 999) / 1000;
endpackage

// ==== rtl/smr_sync.sv ====
`timescale 1ns/10ps
module smr_sync
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             i_clk,
	input  wire logic             i_resetn,
	input  wire logic             i_ce,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;

	// ***************************************************************
	// Two-flop synchroniser per bit
	// ***************************************************************
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			meta_q <= '0;
			o_sync <= '0;
		end
		else if (i_ce)
		begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule

// ==== rtl/smr_top.sv ====
// How it works
// RULE1 - Control bits [6:4] pick the watched supply: digital, bus A, bus B, I/O.
// RULE2 - Control bits [3:0] pick one of up to 15 trip levels; the code passes all 16 codes of the 4-bit field through.
// RULE3 - Software disables the detector before changing the threshold.
// RULE4 - Control bit [7] turns the low supply detector on or off.
// RULE5 - A qualifying trip sets pending flag bit [1] of status.
// RULE6 - Pending flag reaches the processor only when its mask bit is 1.
// RULE7 - Config bits [1:0] choose edge: 2 falling, 3 both, reset none.
// RULE8 - Writing 1 clears the pending flag unless the low condition persists; the code also clears it while edge select is none.
// RULE9 - Software waits 8 us after enabling before trusting the interrupt.
// RULE10 - Software masks, configures, enables, waits, clears, then unmasks.
// RULE11 - Detector runs only in active, low power active, sleep, low power sleep.
// RULE12 - Software drops falling-edge detection around deep sleep.
// RULE13 - Reset holds while either brownout detector reports an unsafe level.
// RULE14 - No brownout reset while in hibernate.
// RULE15 - Over-voltage on the core supply resets, except in hibernate.
// RULE16 - Reset holds until both digital and analogue supplies are present.
// RULE17 - Power-on detector resets during ramp, then is disabled.
// RULE18 - A set register lets software force status bits.
// RULE19 - Masked view is status AND mask.
// RULE20 - Comparator output is synchronised before edge detection.
`timescale 1ns/10ps
module smr_top
#(
	parameter int RELEASE_CYCLES = smr_pkg::RELEASE_CYC
)
(
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_ce,
	input  wire logic [3:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	input  wire logic [2:0]  i_power_mode,
	input  wire logic        i_power_on_trip,
	input  wire logic        i_digital_supply_brownout,
	input  wire logic        i_core_supply_brownout,
	input  wire logic        i_overvoltage_guard,
	input  wire logic        i_digital_supply_good,
	input  wire logic        i_analog_supply_good,
	input  wire logic        i_low_supply_trip,
	output logic             o_system_resetn,
	output logic             o_power_on_detector_enable,
	output logic             o_detector_enable,
	output logic      [2:0]  o_detector_source_select,
	output logic      [3:0]  o_detector_threshold_select,
	output logic             o_irq
);
	localparam int CNT_W = $clog2(RELEASE_CYCLES + 1);

	logic [smr_pkg::CTL_W-1:0]  ctl_q;
	logic [smr_pkg::INTR_W-1:0] status_q;
	logic [smr_pkg::INTR_W-1:0] mask_q;
	logic [smr_pkg::EDGE_W-1:0] edge_sel_q;
	logic [4:0]                 cause_q;
	logic [1:0]                 hib_q;
	logic [CNT_W-1:0]           cnt_q;
	smr_pkg::smr_state_type     state_q;

	logic [5:0] async_in;
	logic [5:0] sync_out;
	logic       trip_s;
	logic       por_s;
	logic       dbod_s;
	logic       cbod_s;
	logic       ovp_s;
	logic       supplies_s;
	logic       mode_ok;
	logic       no_hib;
	logic       gated_trip;
	logic       trip_event;
	logic       reset_req;
	logic       wr_ctl;
	logic       wr_intr;
	logic       wr_set;
	logic       wr_mask;
	logic       wr_cfg;
	logic [4:0] cause_now;

	// ***************************************************************
	// Input synchronisers
	// ***************************************************************
	assign async_in = {i_low_supply_trip, i_power_on_trip, i_digital_supply_brownout,
		i_core_supply_brownout, i_overvoltage_guard,
		i_digital_supply_good & i_analog_supply_good};

	smr_sync #(.WIDTH(6)) u_sync
	(
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_ce     (i_ce),
		.i_async  (async_in),
		.o_sync   (sync_out)
	); // [RULE20]

	assign trip_s     = sync_out[5];
	assign por_s      = sync_out[4];
	assign dbod_s     = sync_out[3];
	assign cbod_s     = sync_out[2];
	assign ovp_s      = sync_out[1];
	assign supplies_s = sync_out[0];

	// ***************************************************************
	// Power mode qualification
	// ***************************************************************
	assign mode_ok = (i_power_mode == smr_pkg::PM_ACTIVE)
		|| (i_power_mode == smr_pkg::PM_LP_ACTIVE)
		|| (i_power_mode == smr_pkg::PM_SLEEP)
		|| (i_power_mode == smr_pkg::PM_LP_SLEEP); // [RULE11]
	assign no_hib = (i_power_mode != smr_pkg::PM_HIBERNATE) && !(|hib_q); // [RULE14]

	// Hold hibernate masking until stale synchronised causes drain
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			hib_q <= '0;
		else if (i_ce)
			hib_q <= {hib_q[0], i_power_mode == smr_pkg::PM_HIBERNATE};
	end

	// Trip only counts while detector on and mode allows it
	assign gated_trip = trip_s & ctl_q[smr_pkg::EN_BIT] & mode_ok; // [RULE4] [RULE11]

	smr_edge u_edge
	(
		.i_clk      (i_clk),
		.i_resetn   (i_resetn),
		.i_ce       (i_ce),
		.i_level    (gated_trip),
		.i_edge_sel (edge_sel_q),
		.o_event    (trip_event)
	); // [RULE7] [RULE20]

	// ***************************************************************
	// Reset request sources
	// ***************************************************************
	assign cause_now = {por_s,
		dbod_s & no_hib,
		cbod_s & no_hib,
		ovp_s & no_hib,
		~supplies_s}; // [RULE13] [RULE14] [RULE15] [RULE16]
	assign reset_req = |cause_now;

	// ***************************************************************
	// Register write decode
	// ***************************************************************
	always_comb
	begin
		wr_ctl  = 1'b0;
		wr_intr = 1'b0;
		wr_set  = 1'b0;
		wr_mask = 1'b0;
		wr_cfg  = 1'b0;
		if (i_wr && i_addr == smr_pkg::ADDR_LVD_CTL)
			wr_ctl = 1'b1;
		else if (i_wr && i_addr == smr_pkg::ADDR_INTR)
			wr_intr = 1'b1;
		else if (i_wr && i_addr == smr_pkg::ADDR_INTR_SET)
			wr_set = 1'b1;
		else if (i_wr && i_addr == smr_pkg::ADDR_INTR_MASK)
			wr_mask = 1'b1;
		else if (i_wr && i_addr == smr_pkg::ADDR_INTR_CFG)
			wr_cfg = 1'b1;
	end

	// ***************************************************************
	// Detector control register
	// ***************************************************************
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			ctl_q <= smr_pkg::LVD_CTL_RESET;
		else if (i_ce && wr_ctl)
			ctl_q <= i_wdata[smr_pkg::CTL_W-1:0]; // [RULE1] [RULE2] [RULE4]
	end

	// ***************************************************************
	// Mask and edge config
	// ***************************************************************
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			mask_q     <= smr_pkg::INTR_RESET;
			edge_sel_q <= smr_pkg::EDGE_NONE;
		end
		else if (i_ce)
		begin
			if (wr_mask)
				mask_q <= {i_wdata[smr_pkg::LVD_BIT], 1'b0};
			if (wr_cfg)
				edge_sel_q <= i_wdata[smr_pkg::EDGE_LSB +: smr_pkg::EDGE_W]; // [RULE7]
		end
	end

	// ***************************************************************
	// Pending status flag
	// ***************************************************************
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			status_q <= smr_pkg::INTR_RESET;
		else if (i_ce)
		begin
			// Set beats clear; a live low condition keeps it set unless edge select is none
			if (trip_event || (wr_set && i_wdata[smr_pkg::LVD_BIT]))
				status_q[smr_pkg::LVD_BIT] <= 1'b1; // [RULE5] [RULE18]
			else if (wr_intr && i_wdata[smr_pkg::LVD_BIT])
				status_q[smr_pkg::LVD_BIT] <= gated_trip
					&& edge_sel_q != smr_pkg::EDGE_NONE; // [RULE8]
			status_q[0] <= 1'b0;
		end
	end

	// ***************************************************************
	// Interrupt output
	// ***************************************************************
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_irq <= 1'b0;
		else if (i_ce)
			o_irq <= |(status_q & mask_q); // [RULE6]
	end

	// ***************************************************************
	// Reset sequencer
	// ***************************************************************
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state_q <= smr_pkg::ST_POWER_UP;
			cnt_q   <= '0;
		end
		else if (i_ce)
		begin
			case (state_q)
				smr_pkg::ST_POWER_UP:
				begin
					// Ramp ends when no reset cause is left: power-on trip clear, supplies good, no unmasked brownout or over-voltage
					if (!reset_req)
					begin
						state_q <= smr_pkg::ST_RUN;
						cnt_q   <= '0;
					end
				end
				smr_pkg::ST_RUN:
				begin
					if (|cause_now[3:0])
					begin
						state_q <= smr_pkg::ST_HOLD; // [RULE13] [RULE15]
						cnt_q   <= '0;
					end
				end
				smr_pkg::ST_HOLD:
				begin
					if (|cause_now[3:0])
						cnt_q <= '0;
					else if (cnt_q == CNT_W'(RELEASE_CYCLES))
						state_q <= smr_pkg::ST_RUN;
					else
						cnt_q <= cnt_q + 1'b1;
				end
				default:
					state_q <= smr_pkg::ST_POWER_UP;
			endcase
		end
	end

	// ***************************************************************
	// Reset and detector outputs
	// ***************************************************************
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_system_resetn             <= 1'b0;
			o_power_on_detector_enable  <= 1'b1;
			o_detector_enable           <= 1'b0;
			o_detector_source_select    <= smr_pkg::SRC_DIGITAL;
			o_detector_threshold_select <= 4'h0;
		end
		else if (i_ce)
		begin
			o_system_resetn <= (state_q == smr_pkg::ST_RUN) && !reset_req; // [RULE16]
			if (state_q == smr_pkg::ST_RUN)
				o_power_on_detector_enable <= 1'b0; // [RULE17]
			o_detector_enable           <= ctl_q[smr_pkg::EN_BIT] & mode_ok; // [RULE4] [RULE11]
			o_detector_source_select    <= ctl_q[smr_pkg::SRC_LSB +: smr_pkg::SRC_W]; // [RULE1]
			o_detector_threshold_select <= ctl_q[smr_pkg::TRIP_LSB +: smr_pkg::TRIP_W]; // [RULE2]
		end
	end

	// ***************************************************************
	// Reset cause capture
	// ***************************************************************
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			cause_q <= '0;
		else if (i_ce)
			cause_q <= cause_q | cause_now; // Sticky, no software clear
	end

	// ***************************************************************
	// Read data
	// ***************************************************************
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_rdata <= smr_pkg::READ_ZERO;
		else if (i_ce)
		begin
			o_rdata <= smr_pkg::READ_ZERO;
			if (i_rd && i_addr == smr_pkg::ADDR_LVD_CTL)
				o_rdata <= {24'h000000, ctl_q};
			else if (i_rd && i_addr == smr_pkg::ADDR_INTR)
				o_rdata <= {30'h0, status_q};
			else if (i_rd && i_addr == smr_pkg::ADDR_INTR_SET)
				o_rdata <= {30'h0, status_q};
			else if (i_rd && i_addr == smr_pkg::ADDR_INTR_MASK)
				o_rdata <= {30'h0, mask_q};
			else if (i_rd && i_addr == smr_pkg::ADDR_INTR_MASKED)
				o_rdata <= {30'h0, status_q & mask_q}; // [RULE19]
			else if (i_rd && i_addr == smr_pkg::ADDR_INTR_CFG)
				o_rdata <= {30'h0, edge_sel_q};
			else if (i_rd && i_addr == smr_pkg::ADDR_RESET_STATUS)
				o_rdata <= {27'h0, cause_q};
		end
	end
endmodule

// ==== sim/smr_supply_model.sv ====
`timescale 1ns/10ps
module smr_supply_model
(
	input  wire logic [6:0] i_level,
	output logic      [6:0] o_cmp
);
	// Comparators settle off the clock grid
	assign #1.3 o_cmp = i_level;
endmodule

// ==== sim/smr_top_checker.sv ====
`timescale 1ns/10ps
module smr_top_checker
(
	input wire logic        i_clk,
	input wire logic        i_resetn,
	input wire logic        i_ce,
	input wire logic [3:0]  i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic [2:0]  i_power_mode,
	input wire logic        i_digital_supply_brownout,
	input wire logic        i_core_supply_brownout,
	input wire logic        i_overvoltage_guard,
	input wire logic        i_digital_supply_good,
	input wire logic        i_analog_supply_good,
	input wire logic        o_system_resetn,
	input wire logic        o_power_on_detector_enable,
	input wire logic        o_detector_enable,
	input wire logic [2:0]  o_detector_source_select,
	input wire logic [3:0]  o_detector_threshold_select,
	input wire logic        o_irq
);
	logic mask_q;
	wire  ctl_wr = i_ce && i_wr && i_addr == smr_pkg::ADDR_LVD_CTL;
	wire  not_hib = i_ce && i_power_mode != smr_pkg::PM_HIBERNATE;

	// Shadow of the pending flag's mask bit
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			mask_q <= 1'b0;
		else if (i_ce && i_wr && i_addr == smr_pkg::ADDR_INTR_MASK)
			mask_q <= i_wdata[1];
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);

	chk_src_copy: assert property (ctl_wr ##1 (i_ce && !ctl_wr) |=>
		o_detector_source_select == $past(i_wdata[6:4], 2)) else $error("source copy");
	chk_trip_copy: assert property (ctl_wr ##1 (i_ce && !ctl_wr) |=>
		o_detector_threshold_select == $past(i_wdata[3:0], 2)) else $error("trip copy");
	chk_deep_off: assert property ((i_ce && i_power_mode > 3'h3)[*2]
		|-> !o_detector_enable) else $error("detector on in deep mode");
	chk_irq_mask: assert property (o_irq |-> $past(mask_q))
		else $error("irq while masked");
	chk_brownout_hold: assert property ((not_hib &&
		(i_digital_supply_brownout || i_core_supply_brownout))[*6] |-> !o_system_resetn)
		else $error("brownout without reset");
	chk_overvolt_hold: assert property ((not_hib && i_overvoltage_guard)[*6]
		|-> !o_system_resetn) else $error("overvoltage without reset");
	chk_supply_hold: assert property ((i_ce &&
		!(i_digital_supply_good && i_analog_supply_good))[*6] |-> !o_system_resetn)
		else $error("reset released without supplies");
	chk_por_off: assert property (!o_power_on_detector_enable |=>
		!o_power_on_detector_enable) else $error("power-on detector back on");
endmodule

bind smr_top smr_top_checker u_smr_top_checker (.i_clk(i_clk), .i_resetn(i_resetn),
	.i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_power_mode(i_power_mode), .i_digital_supply_brownout(i_digital_supply_brownout),
	.i_core_supply_brownout(i_core_supply_brownout), .i_overvoltage_guard(i_overvoltage_guard),
	.i_digital_supply_good(i_digital_supply_good), .i_analog_supply_good(i_analog_supply_good),
	.o_system_resetn(o_system_resetn), .o_detector_enable(o_detector_enable),
	.o_power_on_detector_enable(o_power_on_detector_enable),
	.o_detector_source_select(o_detector_source_select),
	.o_detector_threshold_select(o_detector_threshold_select), .o_irq(o_irq));

// ==== sim/tb.sv ====
`timescale 1ns/10ps
module tb;
	logic        i_clk = 1'b0;
	logic        i_resetn = 1'b0;
	logic        i_ce = 1'b1;
	logic [3:0]  i_addr = 4'h0;
	logic [31:0] i_wdata = 32'h0;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic [2:0]  i_power_mode = 3'h0;
	// Bits: por, dig bod, core bod, ovp, dig good, ana good, low trip
	logic [6:0]  sup = 7'h01;
	logic [6:0]  cmp;
	logic [31:0] o_rdata;
	logic [2:0]  o_src;
	logic [3:0]  o_thr;
	logic        o_system_resetn, o_por_en, o_detector_enable, o_irq;
	int          fails = 0;
	int          num_checks = 0;

	always #2 i_clk = ~i_clk;

	smr_supply_model u_smr_supply_model (.i_level(sup), .o_cmp(cmp));

	smr_top #(.RELEASE_CYCLES(2)) u_smr_top (.i_clk(i_clk), .i_resetn(i_resetn),
		.i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_power_mode(i_power_mode), .i_power_on_trip(cmp[0]),
		.i_digital_supply_brownout(cmp[1]), .i_core_supply_brownout(cmp[2]),
		.i_overvoltage_guard(cmp[3]), .i_digital_supply_good(cmp[4]),
		.i_analog_supply_good(cmp[5]), .i_low_supply_trip(cmp[6]),
		.o_system_resetn(o_system_resetn), .o_power_on_detector_enable(o_por_en),
		.o_detector_enable(o_detector_enable), .o_detector_source_select(o_src),
		.o_detector_threshold_select(o_thr), .o_irq(o_irq));

	// ********
	// Helpers
	// ********
	task automatic end_of_test;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic ck(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
		@(posedge i_clk);
	endtask

	task automatic rdck(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		ck(d, exp);
	endtask

	task automatic wait_rst(input logic v);
		#1;
		repeat (100) if (o_system_resetn !== v) #4;
		ck(o_system_resetn, v);
		@(posedge i_clk);
	endtask

	// ********
	// Scenarios
	// ********
	task automatic t_power_up;
		repeat (20) @(posedge i_clk);
		ck(o_system_resetn, 0);
		ck(o_por_en, 1);
		sup <= 7'h10;
		repeat (20) @(posedge i_clk);
		ck(o_system_resetn, 0);
		sup <= 7'h30;
		wait_rst(1);
		repeat (2) @(posedge i_clk);
		ck(o_por_en, 0);
	endtask

	task automatic t_faults;
		for (int i = 1; i < 4; i++)
		begin
			sup <= 7'h30 | 7'(1 << i);
			wait_rst(0);
			sup <= 7'h30;
			wait_rst(1);
			i_power_mode <= smr_pkg::PM_HIBERNATE;
			repeat (4) @(posedge i_clk);
			sup <= 7'h30 | 7'(1 << i);
			repeat (20) @(posedge i_clk);
			ck(o_system_resetn, 1);
			sup <= 7'h30;
			i_power_mode <= smr_pkg::PM_ACTIVE;
			repeat (4) @(posedge i_clk);
			ck(o_system_resetn, 1);
		end
	endtask

	task automatic t_regs;
		rdck(smr_pkg::ADDR_LVD_CTL, 32'h0);
		rdck(smr_pkg::ADDR_INTR, 32'h0);
		rdck(smr_pkg::ADDR_INTR_CFG, 32'h0);
		wr(smr_pkg::ADDR_INTR_MASK, 32'hFFFF_FFFF);
		rdck(smr_pkg::ADDR_INTR_MASK, 32'h2);
		wr(4'hF, 32'hFFFF_FFFF);
		rdck(4'hF, 32'h0);
		rdck(smr_pkg::ADDR_RESET_STATUS, 32'h1F);
	endtask

	task automatic t_ctl;
		wr(smr_pkg::ADDR_INTR_MASK, 32'h0);
		for (int s = 0; s < 4; s++)
		begin
			wr(smr_pkg::ADDR_LVD_CTL, 32'(s * 16 + 15 - s));
			repeat (2) @(posedge i_clk);
			ck(o_src, 32'(s));
			ck(o_thr, 32'(15 - s));
			ck(o_detector_enable, 0);
		end
		wr(smr_pkg::ADDR_INTR_CFG, 32'h3);
		wr(smr_pkg::ADDR_LVD_CTL, 32'hBC);
		repeat (2000) @(posedge i_clk);
		wr(smr_pkg::ADDR_INTR, 32'h2);
		rdck(smr_pkg::ADDR_LVD_CTL, 32'hBC);
		wr(smr_pkg::ADDR_INTR_CFG, 32'h1);
		for (int m = 0; m < 6; m++)
		begin
			i_power_mode <= 3'(m);
			repeat (4) @(posedge i_clk);
			ck(o_detector_enable, m < 4);
		end
		i_power_mode <= smr_pkg::PM_ACTIVE;
	endtask

	task automatic t_edges;
		logic [31:0] f;
		logic [31:0] r;
		for (int c = 0; c < 4; c++)
		begin
			wr(smr_pkg::ADDR_INTR_CFG, 32'h0);
			sup <= 7'h70;
			repeat (8) @(posedge i_clk);
			wr(smr_pkg::ADDR_INTR, 32'h2);
			wr(smr_pkg::ADDR_INTR_CFG, 32'(c));
			sup <= 7'h30;
			repeat (8) @(posedge i_clk);
			rd(smr_pkg::ADDR_INTR, f);
			wr(smr_pkg::ADDR_INTR_CFG, 32'h0);
			wr(smr_pkg::ADDR_INTR, 32'h2);
			wr(smr_pkg::ADDR_INTR_CFG, 32'(c));
			sup <= 7'h70;
			repeat (8) @(posedge i_clk);
			rd(smr_pkg::ADDR_INTR, r);
			ck(f, (c >= 2) ? 32'h2 : 32'h0);
			ck(r, (c == 1 || c == 3) ? 32'h2 : 32'h0);
		end
	endtask

	task automatic t_irq;
		wr(smr_pkg::ADDR_INTR, 32'h2);
		rdck(smr_pkg::ADDR_INTR, 32'h2);
		ck(o_irq, 0);
		rdck(smr_pkg::ADDR_INTR_MASKED, 32'h0);
		wr(smr_pkg::ADDR_INTR_MASK, 32'h2);
		repeat (2) @(posedge i_clk);
		ck(o_irq, 1);
		rdck(smr_pkg::ADDR_INTR_MASKED, 32'h2);
		sup <= 7'h30;
		repeat (8) @(posedge i_clk);
		wr(smr_pkg::ADDR_INTR, 32'h2);
		rdck(smr_pkg::ADDR_INTR, 32'h0);
		ck(o_irq, 0);
		wr(smr_pkg::ADDR_INTR_SET, 32'h2);
		rdck(smr_pkg::ADDR_INTR, 32'h2);
		ck(o_irq, 1);
	endtask

	task automatic t_hold;
		i_ce <= 1'b0;
		sup <= 7'h32;
		wr(smr_pkg::ADDR_LVD_CTL, 32'h0);
		repeat (10) @(posedge i_clk);
		ck(o_system_resetn, 1);
		i_ce <= 1'b1;
		wait_rst(0);
		sup <= 7'h30;
		wait_rst(1);
		rdck(smr_pkg::ADDR_LVD_CTL, 32'hBC);
	endtask

	initial
	begin
		repeat (2) @(posedge i_clk);
		i_resetn <= 1'b1;
		t_power_up;
		t_faults;
		t_regs;
		t_ctl;
		t_edges;
		t_irq;
		t_hold;
		end_of_test;
	end

	initial
	begin
		#100000;
		fails++;
		end_of_test;
	end
endmodule
